// ===== hw/cmc_pkg.sv
// package of the can mode control and status block: register map, field positions, reset values, types
// assumes a classic wishbone slave with 32-bit data and byte addresses
package cmc_pkg;
	localparam logic [3:0] CMC_CTRL_ADDR = 4'h0;
	localparam logic [3:0] CMC_STAT_ADDR = 4'h4;
	localparam logic [31:0] CMC_CTRL_RESET = 32'h00010002;
	localparam logic [31:0] CMC_STAT_RESET = 32'h00000c02;
	localparam int CTRL_FREEZE = 16;
	localparam int CTRL_MRESET = 15;
	localparam int CTRL_TTCOMM = 7;
	localparam int CTRL_AUTOBO = 6;
	localparam int CTRL_AUTOWK = 5;
	localparam int CTRL_NORETX = 4;
	localparam int CTRL_FLOCK = 3;
	localparam int CTRL_TXPRIO = 2;
	localparam int CTRL_SLEEP = 1;
	localparam int CTRL_INIT = 0;
	localparam int STAT_RXPIN = 11;
	localparam int STAT_LAST_SAMPLE_VALUE = 10;
	localparam int STAT_RXM = 9;
	localparam int STAT_TXM = 8;
	localparam int STAT_SLKI = 4;
	localparam int STAT_WAKEUP_IRQ_FLAG = 3;
	localparam int STAT_ERROR_IRQ_FLAG = 2;
	localparam int STAT_SLEEP_ACK = 1;
	localparam int STAT_INIT_ACK = 0;
	localparam int RECESSIVE_RUN = 11;
	localparam int RECOVERY_RUNS = 128;
	localparam logic [8:0] TEC_BUSOFF_LIMIT = 9'h0ff;
	typedef enum logic [1:0] {MODE_SLEEP, MODE_INIT, MODE_NORMAL} cmc_mode_type;
	typedef struct packed {
		logic freeze;
		logic timeTrig;
		logic autoBusoff;
		logic autoWakeup;
		logic noRetransmit;
		logic fifoLock;
		logic txPrioOrder;
	} cmc_config_type;
	typedef struct packed {
		logic rxActive;
		logic txActive;
		logic sampleValue;
		logic bitTick;
		logic frameBusy;
		logic sofSeen;
		logic errorEvent;
	} cmc_core_type;
endpackage

// ===== hw/cmc_recessive_counter.sv
// counts consecutive recessive bits and completed runs of them
// assumes bitTick is a one-cycle enable at each sample point, same clock
`timescale 1ns/10ps
module cmc_recessive_counter import cmc_pkg::*; #(
	parameter int RUN_LEN = RECESSIVE_RUN,
	parameter int RUN_COUNT = RECOVERY_RUNS
) (
	input wire logic core_clk, // clock
	input wire logic rst_n, // async reset, low
	input wire logic clear, // restart counting
	input wire logic enable, // observe the line
	input wire logic bitTick, // sample point pulse
	input wire logic sampleValue, // sampled bit, one is recessive
	output logic runDone, // pulse: one run of recessive bits completed
	output logic allRunsDone // level: required number of runs seen
);
	logic [3:0] bitCnt_reg;
	logic [7:0] runCnt_reg;
	logic runDone_reg;
	logic hit;
	assign hit = enable && bitTick && sampleValue && (bitCnt_reg == 4'(RUN_LEN - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_reg <= 4'h0;
		end else if (clear || (enable && bitTick && (!sampleValue || hit))) begin
			bitCnt_reg <= 4'h0;
		end else if (enable && bitTick) begin
			bitCnt_reg <= bitCnt_reg + 4'h1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			runCnt_reg <= 8'h00;
		end else if (clear) begin
			runCnt_reg <= 8'h00;
		end else if (hit && !allRunsDone) begin
			runCnt_reg <= runCnt_reg + 8'h01;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			runDone_reg <= 1'b0;
		end else begin
			runDone_reg <= hit && !clear;
		end
	end
	assign runDone = runDone_reg;
	assign allRunsDone = ({1'b0, runCnt_reg} >= 9'(RUN_COUNT));
endmodule // cmc_recessive_counter

// ===== hw/cmc_mode_ctrl.sv
// top of can mode control and status: wishbone registers, mode machine, bus-off recovery
// assumes core status arrives on core_clk; the receive pin is asynchronous and synchronised here
`timescale 1ns/10ps
module cmc_mode_ctrl import cmc_pkg::*; (
	input wire logic core_clk, // 10 MHz clock
	input wire logic rst_n, // async reset, low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // write enable
	input wire logic [3:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic wb_err_o, // unmapped address
	input wire logic canRxPin, // receive pin, asynchronous
	input wire cmc_core_type coreStat, // protocol core status
	input wire logic [8:0] txErrorCount, // tx error counter
	input wire logic debugHalt, // processor in debug
	input wire logic sleepIrqEnable, // enables from interrupt enable register
	input wire logic wakeupIrqEnable, // wakeup enable
	input wire logic errorIrqEnable, // error enable
	output cmc_config_type cfgOut, // configuration to the core
	output logic coreRun, // core may transmit and receive
	output logic coreReset, // pulse: master reset of core, pending counts
	output logic busOff, // bus-off state
	output logic statusIrq // status change interrupt
);
	logic [31:0] ctrl_reg;
	logic [4:0] flags_reg;
	cmc_mode_type mode_reg;
	logic busOff_reg;
	logic initSeen_reg;
	logic rxMeta_reg;
	logic rxSync_reg;
	logic ack_reg;
	logic err_reg;
	logic [31:0] rdata_reg;
	logic coreRun_reg;
	logic coreReset_reg;
	logic irq_reg;
	cmc_config_type cfg_reg;
	logic inSleep;
	logic inInit;
	logic leaving;
	logic runDone;
	logic allRuns;
	logic recClear;
	logic recEnable;
	logic reqNew;
	logic wrCtrl;
	logic wrStat;
	logic mresetNow;
	logic autoWake;
	logic slakClearNow;
	logic [31:0] statView;
	logic [31:0] ctrlWrite;
	cmc_recessive_counter #(
		.RUN_LEN(RECESSIVE_RUN),
		.RUN_COUNT(RECOVERY_RUNS)
	) u_rec (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(recClear),
		.enable(recEnable),
		.bitTick(coreStat.bitTick),
		.sampleValue(coreStat.sampleValue),
		.runDone(runDone),
		.allRunsDone(allRuns)
	);
	assign reqNew = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign wrCtrl = reqNew && wb_we_i && (wb_adr_i == CMC_CTRL_ADDR);
	assign wrStat = reqNew && wb_we_i && (wb_adr_i == CMC_STAT_ADDR);
	assign inSleep = (mode_reg == MODE_SLEEP);
	assign inInit = (mode_reg == MODE_INIT);
	// byte-lane merge of a control write; reserved bits stay zero
	always_comb begin
		ctrlWrite = ctrl_reg;
		for (int i = 0; i < 4; i++) begin
			if (wb_sel_i[i]) begin
				ctrlWrite[i*8 +: 8] = wb_dat_i[i*8 +: 8];
			end
		end
	end
	assign mresetNow = wrCtrl && ctrlWrite[CTRL_MRESET];
	assign autoWake = inSleep && ctrl_reg[CTRL_AUTOWK] && coreStat.sofSeen;
	// leaving sleep, or leaving init for normal, waits for a recessive run; init to sleep does not wait
	assign leaving = (inSleep && !ctrl_reg[CTRL_SLEEP]) || (inInit && !ctrl_reg[CTRL_INIT]);
	// in bus-off the counter is held clear in init, so recovery only counts in normal and when leaving sleep
	assign recEnable = leaving || (busOff_reg && (mode_reg == MODE_NORMAL));
	assign recClear = mresetNow || (busOff_reg ? inInit : !leaving);
	assign slakClearNow = inSleep && leaving && runDone;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxMeta_reg <= 1'b1;
			rxSync_reg <= 1'b1;
		end else begin
			rxMeta_reg <= canRxPin;
			rxSync_reg <= rxMeta_reg;
		end
	end
	// control register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CMC_CTRL_RESET;
		end else if (mresetNow) begin
			ctrl_reg <= CMC_CTRL_RESET;
		end else begin
			if (wrCtrl) begin
				// writable: freeze and bits 7:0, sleep request included; master reset never stored
				ctrl_reg <= ctrlWrite & (CMC_CTRL_RESET | 32'h000000ff) & ~(32'h1 << CTRL_MRESET);
			end
			if (autoWake) begin
				ctrl_reg[CTRL_SLEEP] <= 1'b0;
			end
		end
	end
	// mode machine; one state at a time keeps the acknowledges exclusive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MODE_SLEEP;
		end else if (mresetNow) begin
			mode_reg <= MODE_SLEEP;
		end else begin
			case (mode_reg)
				MODE_SLEEP: begin
					if (ctrl_reg[CTRL_INIT] && runDone) begin
						mode_reg <= MODE_INIT;
					end else if (slakClearNow) begin
						mode_reg <= MODE_NORMAL;
					end
				end
				MODE_INIT: begin
					if (ctrl_reg[CTRL_SLEEP] && !ctrl_reg[CTRL_INIT]) begin
						mode_reg <= MODE_SLEEP;
					end else if (!ctrl_reg[CTRL_INIT] && runDone) begin
						mode_reg <= MODE_NORMAL;
					end
				end
				MODE_NORMAL: begin
					if (ctrl_reg[CTRL_INIT] && !coreStat.frameBusy) begin
						mode_reg <= MODE_INIT;
					end else if (ctrl_reg[CTRL_SLEEP] && !coreStat.frameBusy) begin
						mode_reg <= MODE_SLEEP;
					end
				end
				default: begin
					mode_reg <= MODE_SLEEP;
				end
			endcase
		end
	end
	// bus-off state and recovery
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busOff_reg <= 1'b0;
			initSeen_reg <= 1'b0;
		end else if (mresetNow) begin
			busOff_reg <= 1'b0;
			initSeen_reg <= 1'b0;
		end else if (!busOff_reg) begin
			busOff_reg <= (txErrorCount > TEC_BUSOFF_LIMIT);
			initSeen_reg <= 1'b0;
		end else begin
			if (inInit) begin
				initSeen_reg <= 1'b1;
			end
			if (allRuns && mode_reg == MODE_NORMAL && (ctrl_reg[CTRL_AUTOBO] || initSeen_reg)) begin
				busOff_reg <= 1'b0;
			end
		end
	end
	// interrupt flags: sleep-ack, wakeup, error; set wins over write-one clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= 5'h00;
		end else if (mresetNow) begin
			flags_reg <= 5'h00;
		end else begin
			if ((mode_reg == MODE_NORMAL || inInit) && ctrl_reg[CTRL_SLEEP] && !ctrl_reg[CTRL_INIT]
				&& !coreStat.frameBusy && sleepIrqEnable) begin
				flags_reg[STAT_SLKI] <= 1'b1;
			end else if (slakClearNow || (wrStat && wb_sel_i[0] && wb_dat_i[STAT_SLKI])) begin
				flags_reg[STAT_SLKI] <= 1'b0;
			end
			if (inSleep && coreStat.sofSeen) begin
				flags_reg[STAT_WAKEUP_IRQ_FLAG] <= 1'b1;
			end else if (wrStat && wb_sel_i[0] && wb_dat_i[STAT_WAKEUP_IRQ_FLAG]) begin
				flags_reg[STAT_WAKEUP_IRQ_FLAG] <= 1'b0;
			end
			if (coreStat.errorEvent && errorIrqEnable) begin
				flags_reg[STAT_ERROR_IRQ_FLAG] <= 1'b1;
			end else if (wrStat && wb_sel_i[0] && wb_dat_i[STAT_ERROR_IRQ_FLAG]) begin
				flags_reg[STAT_ERROR_IRQ_FLAG] <= 1'b0;
			end
		end
	end
	// status view; read-only bits come from live state
	always_comb begin
		statView = 32'h0;
		statView[STAT_RXPIN] = rxSync_reg;
		statView[STAT_LAST_SAMPLE_VALUE] = coreStat.sampleValue;
		statView[STAT_RXM] = coreStat.rxActive;
		statView[STAT_TXM] = coreStat.txActive;
		statView[STAT_SLKI] = flags_reg[STAT_SLKI];
		statView[STAT_WAKEUP_IRQ_FLAG] = flags_reg[STAT_WAKEUP_IRQ_FLAG];
		statView[STAT_ERROR_IRQ_FLAG] = flags_reg[STAT_ERROR_IRQ_FLAG];
		statView[STAT_SLEEP_ACK] = inSleep;
		statView[STAT_INIT_ACK] = inInit;
	end
	// wishbone: ack or err one cycle after the request, dropped the next cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg <= reqNew && (wb_adr_i == CMC_CTRL_ADDR || wb_adr_i == CMC_STAT_ADDR);
			err_reg <= reqNew && !(wb_adr_i == CMC_CTRL_ADDR || wb_adr_i == CMC_STAT_ADDR);
			if (reqNew && !wb_we_i) begin
				rdata_reg <= (wb_adr_i == CMC_CTRL_ADDR) ? ctrl_reg : (wb_adr_i == CMC_STAT_ADDR) ? statView : 32'h0;
			end
		end
	end
	// outputs to the core
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= '0;
			coreRun_reg <= 1'b0;
			coreReset_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			cfg_reg.freeze <= ctrl_reg[CTRL_FREEZE];
			cfg_reg.timeTrig <= ctrl_reg[CTRL_TTCOMM];
			cfg_reg.autoBusoff <= ctrl_reg[CTRL_AUTOBO];
			cfg_reg.autoWakeup <= ctrl_reg[CTRL_AUTOWK];
			cfg_reg.noRetransmit <= ctrl_reg[CTRL_NORETX];
			cfg_reg.fifoLock <= ctrl_reg[CTRL_FLOCK];
			cfg_reg.txPrioOrder <= ctrl_reg[CTRL_TXPRIO];
			// frozen in debug only when freeze set; fifos are outside this gate
			coreRun_reg <= (mode_reg == MODE_NORMAL) && !busOff_reg && !(ctrl_reg[CTRL_FREEZE] && debugHalt);
			coreReset_reg <= mresetNow;
			irq_reg <= (flags_reg[STAT_SLKI] && sleepIrqEnable) || (flags_reg[STAT_WAKEUP_IRQ_FLAG] && wakeupIrqEnable)
				|| (flags_reg[STAT_ERROR_IRQ_FLAG] && errorIrqEnable);
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdata_reg;
	assign cfgOut = cfg_reg;
	assign coreRun = coreRun_reg;
	assign coreReset = coreReset_reg;
	assign busOff = busOff_reg;
	assign statusIrq = irq_reg;
endmodule // cmc_mode_ctrl

// ===== tb/cmc_mode_sva.sv
// checker of the mode control block: bus answers, reserved bits, bus-off, freeze, interrupts
// assumes it is bound to cmc_mode_ctrl and sees only its ports
`timescale 1ns/10ps
module cmc_mode_sva import cmc_pkg::*; (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, low
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [3:0] wb_adr_i, // address
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire logic wb_err_o, // error
	input wire logic [8:0] txErrorCount, // tx error counter
	input wire logic debugHalt, // debug
	input wire logic sleepIrqEnable, // enable
	input wire logic wakeupIrqEnable, // enable
	input wire logic errorIrqEnable, // enable
	input wire cmc_config_type cfgOut, // config
	input wire logic coreRun, // run
	input wire logic busOff, // bus-off
	input wire logic statusIrq // irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic req;
	logic rdCtrl_reg;
	logic rdStat_reg;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	// remembers which register the pending read targets
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdCtrl_reg <= 1'b0;
			rdStat_reg <= 1'b0;
		end else if (req) begin
			rdCtrl_reg <= !wb_we_i && wb_adr_i == 4'h0;
			rdStat_reg <= !wb_we_i && wb_adr_i == 4'h4;
		end
	end
	a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("bus request not answered once");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_err_unmapped: assert property (req && wb_adr_i != 4'h0 && wb_adr_i != 4'h4 |=> wb_err_o) else $error("no error");
	a_ctrl_rsvd: assert property (wb_ack_o && rdCtrl_reg |-> wb_dat_o[31:17] == 0 && wb_dat_o[15:8] == 0)
		else $error("control reserved bits set");
	a_stat_rsvd: assert property (wb_ack_o && rdStat_reg |-> wb_dat_o[31:12] == 0 && wb_dat_o[7:5] == 0)
		else $error("status reserved bits set");
	a_mode_excl: assert property (wb_ack_o && rdStat_reg |-> !(wb_dat_o[1] && wb_dat_o[0]))
		else $error("sleep and init both acknowledged");
	a_busoff_enter: assert property (txErrorCount > 9'h0ff |-> ##[1:2] busOff) else $error("bus-off not entered");
	a_busoff_quiet: assert property (busOff && $past(busOff) |-> !coreRun) else $error("running in bus-off");
	a_freeze_halt: assert property ($past(debugHalt) && cfgOut.freeze |-> !coreRun) else $error("runs when frozen");
	a_irq_enable: assert property (statusIrq |-> $past(sleepIrqEnable) || $past(wakeupIrqEnable) || $past(errorIrqEnable))
		else $error("interrupt without enable");
	c_recover: cover property ($fell(busOff));
	c_irq: cover property ($rose(statusIrq));
	c_err: cover property (wb_err_o);
endmodule // cmc_mode_sva

bind cmc_mode_ctrl cmc_mode_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.txErrorCount(txErrorCount), .debugHalt(debugHalt), .sleepIrqEnable(sleepIrqEnable),
	.wakeupIrqEnable(wakeupIrqEnable), .errorIrqEnable(errorIrqEnable), .cfgOut(cfgOut), .coreRun(coreRun),
	.busOff(busOff), .statusIrq(statusIrq));

// ===== tb/cmc_bus_node.sv
// model of the can bus and protocol core: bit ticks every four clocks, frames break recessive runs
// assumes the same clock as the block; idle bus is recessive
`timescale 1ns/10ps
module cmc_bus_node import cmc_pkg::*; (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, low
	input wire logic busy, // a frame is on the bus
	input wire logic sof, // start of frame pulse
	input wire logic err, // error pulse
	output logic canRxPin, // bus level
	output cmc_core_type coreStat // core status
);
	logic [1:0] div_reg;
	logic level_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 2'h0;
			level_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 2'h1;
			// a frame toggles the line so no run of recessive bits forms
			if (div_reg == 2'h3) level_reg <= busy ? ~level_reg : 1'b1;
		end
	end
	assign canRxPin = level_reg;
	assign coreStat = '{rxActive: busy, txActive: 1'b0, sampleValue: level_reg, bitTick: div_reg == 2'h3,
		frameBusy: busy, sofSeen: sof, errorEvent: err};
endmodule // cmc_bus_node

// ===== tb/tb.sv
// self-checking bench of the mode control block with a bus node model
// assumes wishbone answers within a few cycles and a bit tick every four clocks
`timescale 1ns/10ps
module tb import cmc_pkg::*;;
	logic core_clk, rstN, wbCyc, wbStb, wbWe, busy, sof, err, halt, sEn, wEn, eEn, resetSeen, e;
	logic ack, werr, coreRun, coreReset, busOff, statusIrq, canRx;
	logic [3:0] wbAdr, wbSel;
	logic [31:0] wbDat, wbRd, r, w;
	logic [8:0] tx_error_counter;
	cmc_core_type coreStat;
	cmc_config_type cfgOut;
	int failCount, checks, seed, cyc, t0, i;
	cmc_mode_ctrl uut (.core_clk(core_clk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbRd), .wb_ack_o(ack), .wb_err_o(werr),
		.canRxPin(canRx), .coreStat(coreStat), .txErrorCount(tx_error_counter), .debugHalt(halt), .sleepIrqEnable(sEn),
		.wakeupIrqEnable(wEn), .errorIrqEnable(eEn), .cfgOut(cfgOut), .coreRun(coreRun), .coreReset(coreReset),
		.busOff(busOff), .statusIrq(statusIrq));
	cmc_bus_node node (.core_clk(core_clk), .rst_n(rstN), .busy(busy), .sof(sof), .err(err), .canRxPin(canRx),
		.coreStat(coreStat));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		resetSeen <= resetSeen | (coreReset === 1'b1);
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			failCount++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task close_out;
		if (failCount == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		wbSel <= 4'hf;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && werr !== 1'b1 && n < 20);
		if (n >= 20) begin
			failCount++;
			close_out;
		end
		r = wbRd;
		e = werr;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task wbit(input int b, input logic v);
		for (int n = 0; n < 300; n++) begin
			bus(1'b0, CMC_STAT_ADDR, 32'h0);
			if (r[b] === v) return;
		end
		failCount++;
		close_out;
	endtask
	initial begin
		seed = 20651;
		{failCount, checks, cyc} = '0;
		{rstN, wbCyc, wbStb, wbWe, busy, sof, err, halt, sEn, wEn, eEn, resetSeen} = '0;
		{wbAdr, wbSel, wbDat, tx_error_counter} = '0;
		repeat (5) @(posedge core_clk);
		rstN <= 1'b1;
		bus(1'b0, CMC_CTRL_ADDR, 32'h0); chk("ctrlReset", r, CMC_CTRL_RESET);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("statReset", r, CMC_STAT_RESET);
		bus(1'b0, 4'h8, 32'h0); chk("unmapped", 32'(e), 32'h1);
		for (i = 0; i < 4; i++) begin
			w = ($random(seed) & 32'hffff7ffc) | 32'h1;
			bus(1'b1, CMC_CTRL_ADDR, w);
			bus(1'b0, CMC_CTRL_ADDR, 32'h0); chk("ctrlMask", r, w & 32'h000100ff);
			wbit(STAT_INIT_ACK, 1'b1); chk("sleepOff", 32'(r[STAT_SLEEP_ACK]), 32'h0);
			chk("cfgOut", 32'(cfgOut), 32'({w[16], w[7:2]}));
		end
		w = 32'h00010060;
		bus(1'b1, CMC_CTRL_ADDR, w);
		t0 = cyc;
		wbit(STAT_INIT_ACK, 1'b0); chk("initExit", 32'(cyc - t0 >= 40), 32'h1);
		chk("coreRun", 32'(coreRun), 32'h1);
		halt <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("frozen", 32'(coreRun), 32'h0);
		halt <= 1'b0;
		tx_error_counter <= 9'h100;
		@(posedge core_clk);
		tx_error_counter <= 9'h000;
		repeat (2) @(posedge core_clk);
		chk("busOff", 32'(busOff), 32'h1);
		t0 = cyc;
		for (i = 0; i < 8000 && busOff !== 1'b0; i++) @(posedge core_clk);
		chk("recovered", 32'(busOff), 32'h0);
		if (busOff !== 1'b0) close_out;
		chk("recoverTime", 32'(cyc - t0 >= 5600), 32'h1);
		busy <= 1'b1;
		{sEn, wEn, eEn} <= 3'h7;
		bus(1'b1, CMC_CTRL_ADDR, w | 32'h2);
		repeat (60) @(posedge core_clk);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("sleepWait", 32'(r[1]), 32'h0);
		chk("rxMode", 32'(r[9:8]), 32'h2);
		busy <= 1'b0;
		wbit(STAT_SLEEP_ACK, 1'b1); chk("sleepFlag", 32'(r[STAT_SLKI]), 32'h1);
		chk("irq", 32'(statusIrq), 32'h1);
		bus(1'b1, CMC_STAT_ADDR, 32'h0);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("keepFlag", 32'(r[STAT_SLKI]), 32'h1);
		bus(1'b1, CMC_STAT_ADDR, 32'h10);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("clrFlag", 32'(r[STAT_SLKI]), 32'h0);
		err <= 1'b1;
		sof <= 1'b1;
		@(posedge core_clk);
		err <= 1'b0;
		sof <= 1'b0;
		bus(1'b0, CMC_CTRL_ADDR, 32'h0); chk("autoWake", 32'(r[CTRL_SLEEP]), 32'h0);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("wakeErr", 32'(r[4:1]), 32'h7);
		wbit(STAT_SLEEP_ACK, 1'b0);
		bus(1'b1, CMC_STAT_ADDR, 32'hc);
		bus(1'b0, CMC_STAT_ADDR, 32'h0); chk("flagsClr", 32'(r[4:2]), 32'h0);
		bus(1'b1, CMC_CTRL_ADDR, 32'h00008000);
		bus(1'b0, CMC_CTRL_ADDR, 32'h0); chk("masterReset", r, CMC_CTRL_RESET);
		chk("coreReset", 32'(resetSeen), 32'h1);
		bus(1'b1, CMC_CTRL_ADDR, 32'h0);
		wbit(STAT_SLEEP_ACK, 1'b0); chk("swWake", 32'(r[1:0]), 32'h0);
		close_out;
	end
endmodule // tb
